// ===== src/ssrd_top.v
`timescale 1ns/1ns
`default_nettype none
`include "ssrd_consts.vh"
module ssrd_top #(
  parameter NUM_PINS = 8,
  parameter PIN_SEL_W = 3,
  parameter [NUM_PINS-1:0] CLOCK_PIN_MASK = 8'h81,
  parameter NUM_COLS = 2,
  parameter SECT_PER_COL = 2,
  parameter CELLS_PER_SECT = 4
) (
  // Clock and reset
  input wire CLK,
  input wire RST,
  // Avalon-MM slave
  input wire [7:0] AVS_ADDRESS,
  input wire AVS_READ,
  input wire AVS_WRITE,
  input wire [31:0] AVS_WRITEDATA,
  input wire [3:0] AVS_BYTEENABLE,
  output reg [31:0] AVS_READDATA,
  output wire AVS_WAITREQUEST,
  // User pins that may drive the global line
  input wire [NUM_PINS-1:0] USER_PIN,
  // Plane-5 express lines, one per sector
  input wire [NUM_COLS*SECT_PER_COL-1:0] EXPR_P5,
  // Cell registers
  input wire [NUM_COLS*SECT_PER_COL*CELLS_PER_SECT-1:0] CELL_D,
  output wire [NUM_COLS*SECT_PER_COL*CELLS_PER_SECT-1:0] CELL_Q,
  // Global line as seen by each column
  output wire [NUM_COLS-1:0] COL_GSR
);

  localparam NSECT = NUM_COLS * SECT_PER_COL;
  localparam NCELL = NSECT * CELLS_PER_SECT;

  // Reset values as bus words, cut to each register's width where used
  localparam [31:0] GSRC_RST = `SSRD_GSRC_RST;
  localparam [31:0] SSRC_RST = `SSRD_SSRC_RST;
  localparam [31:0] SPOL_RST = `SSRD_SPOL_RST;
  localparam [31:0] CMODE_RST = `SSRD_CMODE_RST;

  // Bus handshake: one wait cycle, answer on the second
  reg ack_q;
  wire req;
  wire wr_now;
  wire [31:0] be_mask;

  // Register selects and write strobes
  wire hit_ctrl;
  wire hit_gsrc;
  wire hit_ssrc;
  wire hit_spol;
  wire hit_cmode;
  wire hit_stat;
  wire hit_slvl;
  wire hit_cellq;
  wire wr_ctrl;
  wire wr_gsrc;
  wire wr_ssrc;
  wire wr_spol;
  wire wr_cmode;

  // Configuration state
  reg cfg_done_q;
  reg [PIN_SEL_W-1:0] pin_sel_q;
  reg [NSECT-1:0] sect_src_q;
  reg [NSECT-1:0] sect_pol_q;
  reg [NCELL-1:0] cell_mode_q;
  reg rejected_q;

  // Datapath
  wire [NUM_PINS-1:0] pin_sync;
  wire gsr;
  wire [NSECT-1:0] sect_lvl;
  reg [31:0] ctrl_word;
  reg [31:0] stat_word;
  wire [31:0] gsrc_wide;
  wire [31:0] ssrc_wide;
  wire [31:0] spol_wide;
  wire [31:0] cmode_wide;
  wire [31:0] slvl_wide;
  wire [31:0] cellq_wide;
  wire [31:0] gsrc_new;
  wire [31:0] ssrc_new;
  wire [31:0] spol_new;
  wire [31:0] cmode_new;
  wire cfg_wr_ok;
  wire [PIN_SEL_W-1:0] pin_req;
  wire pin_ok;
  reg [31:0] rd_d;

  // Byte-lane merge of write data into the current word of a register
  function [31:0] merge_lanes;
    input [31:0] cur;
    input [31:0] wdata;
    input [31:0] mask;
    begin
      merge_lanes = (cur & ~mask) | (wdata & mask);
    end
  endfunction

  assign req = AVS_READ | AVS_WRITE;
  assign AVS_WAITREQUEST = req & ~ack_q;
  assign wr_now = AVS_WRITE & ack_q;

  genvar b;
  generate
    for (b = 0; b < 4; b = b + 1)
    begin : g_lane
      assign be_mask[b*8 +: 8] = {8{AVS_BYTEENABLE[b]}};
    end
  endgenerate

  assign hit_ctrl = (AVS_ADDRESS == `SSRD_CTRL_OFS);
  assign hit_gsrc = (AVS_ADDRESS == `SSRD_GSRC_OFS);
  assign hit_ssrc = (AVS_ADDRESS == `SSRD_SSRC_OFS);
  assign hit_spol = (AVS_ADDRESS == `SSRD_SPOL_OFS);
  assign hit_cmode = (AVS_ADDRESS == `SSRD_CMODE_OFS);
  assign hit_stat = (AVS_ADDRESS == `SSRD_STAT_OFS);
  assign hit_slvl = (AVS_ADDRESS == `SSRD_SLVL_OFS);
  assign hit_cellq = (AVS_ADDRESS == `SSRD_CELLQ_OFS);

  // Changing routing under a live array would glitch cell set/reset inputs
  assign cfg_wr_ok = wr_now & ~cfg_done_q;
  // Control stays writable so software can always fall back to the set state
  assign wr_ctrl = wr_now & hit_ctrl & AVS_BYTEENABLE[0];
  assign wr_gsrc = cfg_wr_ok & hit_gsrc;
  assign wr_ssrc = cfg_wr_ok & hit_ssrc;
  assign wr_spol = cfg_wr_ok & hit_spol;
  assign wr_cmode = cfg_wr_ok & hit_cmode;

  // Zero-extend fields to a bus word
  assign gsrc_wide = {{(32-PIN_SEL_W){1'b0}}, pin_sel_q};
  assign ssrc_wide = {{(32-NSECT){1'b0}}, sect_src_q};
  assign spol_wide = {{(32-NSECT){1'b0}}, sect_pol_q};
  assign cmode_wide = {{(32-NCELL){1'b0}}, cell_mode_q};
  assign slvl_wide = {{(32-NSECT){1'b0}}, sect_lvl};
  assign cellq_wide = {{(32-NCELL){1'b0}}, CELL_Q};

  // Writes honour the byte enables
  assign gsrc_new = merge_lanes(gsrc_wide, AVS_WRITEDATA, be_mask);
  assign ssrc_new = merge_lanes(ssrc_wide, AVS_WRITEDATA, be_mask);
  assign spol_new = merge_lanes(spol_wide, AVS_WRITEDATA, be_mask);
  assign cmode_new = merge_lanes(cmode_wide, AVS_WRITEDATA, be_mask);
  assign pin_req = gsrc_new[PIN_SEL_W-1:0];
  // Clock pins cannot be written as the global line source; an index keeps only its low PIN_SEL_W bits; reset selects pin 0, a clock pin by default
  assign pin_ok = (pin_req < NUM_PINS) && !CLOCK_PIN_MASK[pin_req];

  always @(posedge CLK)
  begin
    if (RST)
      ack_q <= 1'b0;
    else
      ack_q <= req & ~ack_q;
  end

  // Clearing the done bit sets every cell again
  always @(posedge CLK)
  begin
    if (RST)
      cfg_done_q <= `SSRD_CFG_RST;
    else if (wr_ctrl)
      cfg_done_q <= AVS_WRITEDATA[`SSRD_CTRL_CFG_BIT];
  end

  always @(posedge CLK)
  begin
    if (RST)
      pin_sel_q <= GSRC_RST[PIN_SEL_W-1:0];
    else if (wr_gsrc && pin_ok)
      pin_sel_q <= pin_req;
  end

  // A refused index stays flagged until the next accepted one
  always @(posedge CLK)
  begin
    if (RST)
      rejected_q <= 1'b0;
    else if (wr_gsrc)
      rejected_q <= ~pin_ok;
  end

  // Routing settings move only while the array is unconfigured
  always @(posedge CLK)
  begin
    if (RST)
      sect_src_q <= SSRC_RST[NSECT-1:0];
    else if (wr_ssrc)
      sect_src_q <= ssrc_new[NSECT-1:0];
  end

  always @(posedge CLK)
  begin
    if (RST)
      sect_pol_q <= SPOL_RST[NSECT-1:0];
    else if (wr_spol)
      sect_pol_q <= spol_new[NSECT-1:0];
  end

  always @(posedge CLK)
  begin
    if (RST)
      cell_mode_q <= CMODE_RST[NCELL-1:0];
    else if (wr_cmode)
      cell_mode_q <= cmode_new[NCELL-1:0];
  end

  // Word views of control and status
  always @*
  begin
    ctrl_word = 32'h00000000;
    ctrl_word[`SSRD_CTRL_CFG_BIT] = cfg_done_q;
  end

  always @*
  begin
    stat_word = 32'h00000000;
    stat_word[`SSRD_STAT_GSR_BIT] = gsr;
    stat_word[`SSRD_STAT_CFG_BIT] = cfg_done_q;
    stat_word[`SSRD_STAT_REJ_BIT] = rejected_q;
  end

  // Unmapped offsets read zero
  always @*
  begin
    rd_d = 32'h00000000;
    if (hit_ctrl)
      rd_d = ctrl_word;
    else if (hit_gsrc)
      rd_d = gsrc_wide;
    else if (hit_ssrc)
      rd_d = ssrc_wide;
    else if (hit_spol)
      rd_d = spol_wide;
    else if (hit_cmode)
      rd_d = cmode_wide;
    else if (hit_stat)
      rd_d = stat_word;
    else if (hit_slvl)
      rd_d = slvl_wide;
    else if (hit_cellq)
      rd_d = cellq_wide;
  end

  // Read data captured in the wait cycle and held through the answer
  always @(posedge CLK)
  begin
    if (RST)
      AVS_READDATA <= 32'h00000000;
    else if (AVS_READ && !ack_q)
      AVS_READDATA <= rd_d;
  end

  ssrd_sync2 #(
    .WIDTH(NUM_PINS)
  ) u_pin_sync (
    .clk(CLK),
    .async_in(USER_PIN),
    .sync_out(pin_sync)
  );

  // Single global line from the selected pin
  assign gsr = pin_sync[pin_sel_q];

  genvar c;
  genvar s;
  generate
    for (c = 0; c < NUM_COLS; c = c + 1)
    begin : g_col
      assign COL_GSR[c] = gsr;
      for (s = 0; s < SECT_PER_COL; s = s + 1)
      begin : g_sect
        localparam K = c * SECT_PER_COL + s;
        // One selector per group of four cells in the column
        ssrd_sector #(
          .CELLS(CELLS_PER_SECT)
        ) u_sector (
          .clk(CLK),
          .global_sr(COL_GSR[c]),
          .express_sr(EXPR_P5[K]),
          .sel_global(sect_src_q[K]),
          .invert(sect_pol_q[K]),
          .cfg_done(cfg_done_q),
          .cell_set_mode(cell_mode_q[K*CELLS_PER_SECT +: CELLS_PER_SECT]),
          .cell_d(CELL_D[K*CELLS_PER_SECT +: CELLS_PER_SECT]),
          .cell_q(CELL_Q[K*CELLS_PER_SECT +: CELLS_PER_SECT]),
          .sr_level(sect_lvl[K])
        );
      end
    end
  endgenerate

endmodule
`default_nettype wire

// ===== inc/ssrd_consts.vh
`ifndef SSRD_CONSTS_VH
`define SSRD_CONSTS_VH

// Register byte offsets
`define SSRD_CTRL_OFS 8'h00
`define SSRD_GSRC_OFS 8'h04
`define SSRD_SSRC_OFS 8'h08
`define SSRD_SPOL_OFS 8'h0c
`define SSRD_CMODE_OFS 8'h10
`define SSRD_STAT_OFS 8'h14
`define SSRD_SLVL_OFS 8'h18
`define SSRD_CELLQ_OFS 8'h1c

// Field positions
`define SSRD_CTRL_CFG_BIT 0
`define SSRD_STAT_GSR_BIT 0
`define SSRD_STAT_CFG_BIT 1
`define SSRD_STAT_REJ_BIT 2

// Reset values
`define SSRD_CFG_RST 1'b0
`define SSRD_GSRC_RST 32'h00000000
`define SSRD_SSRC_RST 32'h00000000
`define SSRD_SPOL_RST 32'h00000000
`define SSRD_CMODE_RST 32'h00000000

// Delivered level that makes a cell set/reset input act
`define SSRD_SR_ACTIVE_LVL 1'b0

`endif

// ===== src/ssrd_sync2.v
`timescale 1ns/1ns
`default_nettype none
module ssrd_sync2 #(
  parameter WIDTH = 8
) (
  // Clock
  input wire clk,
  // Asynchronous inputs and their synchronised copies
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_q;

  always @(posedge clk)
  begin
    meta_q <= async_in;
    sync_out <= meta_q;
  end

endmodule
`default_nettype wire

// ===== src/ssrd_sector.v
`timescale 1ns/1ns
`default_nettype none
`include "ssrd_consts.vh"
module ssrd_sector #(
  parameter CELLS = 4
) (
  // Clock
  input wire clk,
  // Set/reset sources
  input wire global_sr,
  input wire express_sr,
  // Static configuration
  input wire sel_global,
  input wire invert,
  input wire cfg_done,
  input wire [CELLS-1:0] cell_set_mode,
  // Cell registers
  input wire [CELLS-1:0] cell_d,
  output wire [CELLS-1:0] cell_q,
  output wire sr_level
);

  wire src_sr;
  wire act;

  assign src_sr = sel_global ? global_sr : express_sr;
  assign sr_level = src_sr ^ invert;
  assign act = (sr_level == `SSRD_SR_ACTIVE_LVL);

  genvar i;
  generate
    for (i = 0; i < CELLS; i = i + 1)
    begin : g_cell
      wire set_a;
      wire clr_a;
      reg q_q;
      // Unconfigured cells are held set so they read one from power-up
      assign set_a = ~cfg_done | (act & cell_set_mode[i]);
      assign clr_a = cfg_done & act & ~cell_set_mode[i];
      always @(posedge clk or posedge set_a or posedge clr_a)
      begin
        if (clr_a)
          q_q <= 1'b0;
        else if (set_a)
          q_q <= 1'b1;
        else
          q_q <= cell_d[i];
      end
      assign cell_q[i] = q_q;
    end
  endgenerate

endmodule
`default_nettype wire

// ===== bench/ssrd_pins.sv
`timescale 1ns/1ns
`default_nettype none
module ssrd_pins #(
  parameter N = 8
) (
  // Chosen pin and its level
  input wire logic [2:0] idx,
  input wire logic lvl,
  // User pins
  output logic [N-1:0] pins
);
  // Other pins idle high so they never act as a reset
  assign pins = ~(N'(1) << idx) | (N'(lvl) << idx);
endmodule
`default_nettype wire

// ===== bench/ssrd_chk_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module ssrd_chk #(
  parameter NUM_PINS = 8,
  parameter NUM_COLS = 2,
  parameter SECT_PER_COL = 2,
  parameter CELLS_PER_SECT = 4
) (
  // Clock and reset
  input wire CLK,
  input wire RST,
  // Bus
  input wire AVS_READ,
  input wire AVS_WRITE,
  input wire [7:0] AVS_ADDRESS,
  input wire [31:0] AVS_WRITEDATA,
  input wire [31:0] AVS_READDATA,
  input wire AVS_WAITREQUEST,
  // Set/reset path
  input wire [NUM_PINS-1:0] USER_PIN,
  input wire [NUM_COLS*SECT_PER_COL-1:0] EXPR_P5,
  input wire [NUM_COLS*SECT_PER_COL*CELLS_PER_SECT-1:0] CELL_D,
  input wire [NUM_COLS*SECT_PER_COL*CELLS_PER_SECT-1:0] CELL_Q,
  input wire [NUM_COLS-1:0] COL_GSR
);
  localparam C = CELLS_PER_SECT;
  localparam NS = NUM_COLS * SECT_PER_COL;
  wire req = AVS_READ || AVS_WRITE;
  wire wr = AVS_WRITE && !AVS_WAITREQUEST;
  logic cfg_q;
  logic [NS-1:0] src_q, pol_q;
  logic [NS*C-1:0] mode_q, act;
  // Shadow mirrors the lock, so a setting that leaks through shows up
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      cfg_q <= 1'b0;
      src_q <= '0;
      pol_q <= '0;
      mode_q <= '0;
    end
    else if (wr)
    begin
      if (AVS_ADDRESS == 8'h00)
        cfg_q <= AVS_WRITEDATA[0];
      if (!cfg_q && AVS_ADDRESS == 8'h08)
        src_q <= AVS_WRITEDATA[NS-1:0];
      if (!cfg_q && AVS_ADDRESS == 8'h0c)
        pol_q <= AVS_WRITEDATA[NS-1:0];
      if (!cfg_q && AVS_ADDRESS == 8'h10)
        mode_q <= AVS_WRITEDATA[NS*C-1:0];
    end
  end
  always_comb
  begin
    for (int k = 0; k < NS * C; k++)
      act[k] = !((src_q[k/C] ? COL_GSR[k/C/SECT_PER_COL] : EXPR_P5[k/C]) ^ pol_q[k/C]);
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  chk_one_wait: assert property ($rose(req) |-> AVS_WAITREQUEST ##1 !AVS_WAITREQUEST)
    else $error("bus wait not one cycle");
  chk_idle_nowait: assert property (!req |-> !AVS_WAITREQUEST)
    else $error("wait while idle");
  chk_rd_hold: assert property (!$past(AVS_READ) |-> $stable(AVS_READDATA))
    else $error("read data moved");
  chk_cols_agree: assert property (COL_GSR == {NUM_COLS{COL_GSR[0]}})
    else $error("columns differ");
  chk_gsr_cause: assert property ($changed(COL_GSR) |->
    $past(USER_PIN, 2) != $past(USER_PIN, 3) || $past(wr) || $past(wr, 2) || $past(wr, 3))
    else $error("global line moved alone");
  chk_unconfig_set: assert property (!cfg_q |-> &CELL_Q)
    else $error("cell clear before config");
  chk_forced_mode: assert property (cfg_q |-> ((CELL_Q ^ mode_q) & act) == '0)
    else $error("forced cell wrong");
  chk_free_capture: assert property (cfg_q && $past(cfg_q) |->
    ((CELL_Q ^ $past(CELL_D)) & ~act & ~$past(act)) == '0)
    else $error("free cell wrong");
endmodule
bind ssrd_top ssrd_chk #(.NUM_PINS(NUM_PINS), .NUM_COLS(NUM_COLS), .SECT_PER_COL(SECT_PER_COL),
  .CELLS_PER_SECT(CELLS_PER_SECT)) u_chk (.CLK(CLK), .RST(RST), .AVS_READ(AVS_READ),
  .AVS_WRITE(AVS_WRITE), .AVS_ADDRESS(AVS_ADDRESS), .AVS_WRITEDATA(AVS_WRITEDATA),
  .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .USER_PIN(USER_PIN),
  .EXPR_P5(EXPR_P5), .CELL_D(CELL_D), .CELL_Q(CELL_Q), .COL_GSR(COL_GSR));
`default_nettype wire

// ===== bench/ssrd_top_test.sv
`timescale 1ns/1ns
`default_nettype none
module ssrd_top_test;
  localparam logic [3:0] SRC = 4'h3;
  localparam logic [3:0] POL = 4'h6;
  localparam logic [15:0] MODE = 16'h0f0f;
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic AVS_READ = 1'b0;
  logic AVS_WRITE = 1'b0;
  logic [7:0] AVS_ADDRESS = 8'h00;
  logic [31:0] AVS_WRITEDATA = 32'h0;
  logic [31:0] AVS_READDATA, rd;
  logic AVS_WAITREQUEST;
  logic [2:0] pin_idx = 3'h3;
  logic pin_lvl = 1'b1;
  logic [7:0] USER_PIN;
  logic [3:0] EXPR_P5 = 4'hf, ev;
  logic [15:0] CELL_D = 16'h0, CELL_Q;
  logic [1:0] COL_GSR;
  int fails = 0;
  int n_checks = 0;
  int cyc = 0;
  ssrd_top DUT (.CLK(CLK), .RST(RST), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(4'hf),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .USER_PIN(USER_PIN),
    .EXPR_P5(EXPR_P5), .CELL_D(CELL_D), .CELL_Q(CELL_Q), .COL_GSR(COL_GSR));
  ssrd_pins PINS (.idx(pin_idx), .lvl(pin_lvl), .pins(USER_PIN));
  always #5 CLK = ~CLK;
  task automatic finish_test;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge CLK)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      fails++;
      finish_test;
    end
  end
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e)
    begin
      fails++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    AVS_WRITE <= w;
    AVS_READ <= !w;
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= d;
    do @(posedge CLK);
    while (AVS_WAITREQUEST !== 1'b0);
    rd = AVS_READDATA;
    AVS_WRITE <= 1'b0;
    AVS_READ <= 1'b0;
  endtask
  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(nm, rd, e);
  endtask
  function automatic logic lv(input int s, input logic g, input logic [3:0] x);
    return (SRC[s] ? g : x[s]) ^ POL[s];
  endfunction
  initial
  begin
    repeat (16) @(posedge CLK);
    RST <= 1'b0;
    @(posedge CLK);
    chk("cells", CELL_Q, 32'hffff);
    rdchk("ctrl", 8'h00, 32'h0);
    for (int i = 0; i < 3; i++)
    begin
      bus(1'b1, 8'h04, (i == 0) ? 32'h0 : i + 6);
      bus(1'b0, 8'h14, 32'h0);
      chk("refused", rd & 32'h4, 32'h4);
    end
    bus(1'b1, 8'h04, 32'h3);
    bus(1'b0, 8'h14, 32'h0);
    chk("taken", rd & 32'h4, 32'h0);
    bus(1'b1, 8'h08, SRC);
    bus(1'b1, 8'h0c, POL);
    bus(1'b1, 8'h10, MODE);
    bus(1'b1, 8'h00, 32'h1);
    bus(1'b1, 8'h08, 32'h0);
    rdchk("src", 8'h08, SRC);
    rdchk("pol", 8'h0c, POL);
    rdchk("mode", 8'h10, MODE);
    bus(1'b1, 8'h20, 32'h1);
    rdchk("unmapped", 8'h20, 32'h0);
    $display("setup tests done");
    for (int i = 0; i < 16; i++)
    begin
      pin_lvl <= i[0];
      EXPR_P5 <= i[3:0];
      CELL_D <= {4{i[3:0]}} ^ 16'h5a3c;
      repeat (4) @(posedge CLK);
      for (int k = 0; k < 16; k++)
        chk("cell", CELL_Q[k], lv(k / 4, i[0], i[3:0]) ? CELL_D[k] : MODE[k]);
      chk("column", COL_GSR, {2{i[0]}});
      for (int s = 0; s < 4; s++)
        ev[s] = lv(s, i[0], i[3:0]);
      rdchk("levels", 8'h18, ev);
    end
    bus(1'b1, 8'h00, 32'h0);
    @(posedge CLK);
    chk("cells", CELL_Q, 32'hffff);
    rdchk("cellq", 8'h1c, 32'hffff);
    rdchk("status", 8'h14, 32'h1);
    $display("path tests done");
    finish_test;
  end
endmodule
`default_nettype wire
